// ---- rtl/tw_pkg.sv ----
// Shared constants and types for the two-wire slave front end and its bus master
package tw_pkg;
	// ************************************************
	// Clock and timing
	// ************************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int CLK_FREQ_KHZ = 200000;
	localparam int WRITE_TIME_MS = 5;
	localparam int WRITE_CYCLES = WRITE_TIME_MS * CLK_FREQ_KHZ;
	localparam int HOLD_TIME_NS = 300;
	localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_FREQ_KHZ = 400;
	localparam int SCL_QUARTER_CYCLES = CLK_FREQ_KHZ / (4 * SCL_FREQ_KHZ);
	// ************************************************
	// Data path and control byte
	// ************************************************
	localparam int BYTE_W = 8;
	localparam int PAGE_BYTES = 16;
	localparam logic [3:0] CODE_ARRAY = 4'hA;
	localparam logic [3:0] CODE_PROTECT = 4'h6;
	localparam logic [3:0] BIT_LAST = 4'h8;
	typedef enum logic [1:0] {TW_CMD_START, TW_CMD_WRITE, TW_CMD_READ, TW_CMD_STOP} tw_cmd_t;
endpackage

// ---- rtl/tw_if.sv ----
// Two-wire bus between the slave end and the master end, with wired-AND levels
`timescale 1ns/1ps
`default_nettype none
interface tw_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// Open-drain lines rest high unless a party pulls low
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// ---- rtl/tw_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides and a flush
`timescale 1ns/1ps
`default_nettype none
module tw_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	// ************************************************
	// Status
	// ************************************************
	assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];
	// Pointers
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else if (flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (in_valid && in_ready)
				wr_ptr <= wr_ptr + 1'b1;
			if (out_valid && out_ready)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
	// Storage
	always_ff @(posedge CLK)
	begin
		if (in_valid && in_ready && !flush)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
endmodule
`default_nettype wire

// ---- rtl/tw_dev.sv ----
// Slave end of the two-wire bus: conditions, bit shifting, acknowledges, page buffer
//
// Contract
// - Both lines high means idle bus.
// - Master starts only on an idle bus.
// - SDA change under SCL high is condition.
// - SDA fall under SCL high is Start.
// - SDA rise under SCL high is Stop.
// - One SCL pulse per bit, change low.
// - Keep last sixteen bytes, oldest dropped.
// - Acknowledge every received byte on ninth pulse. Code leaves a refused control byte unacknowledged.
// - Acknowledger holds SDA low through pulse.
// - Master ends read by withholding acknowledge.
// - On withheld acknowledge, release SDA high.
// - Master clocks and frames; device is slave.
// - Internal write finishes within five ms.
// - Hold SDA 300 ns after SCL fall.
// - No control byte acknowledge while writing.
// - Control byte: code, chip select, direction.
`timescale 1ns/1ps
`default_nettype none
module tw_dev
#(
	parameter int WRITE_CYC = tw_pkg::WRITE_CYCLES,
	parameter int DEPTH = tw_pkg::PAGE_BYTES
)
(
	input wire logic CLK,
	input wire logic RESETN,
	tw_if.dev BUS,
	input wire logic [2:0] CHIP_SEL,
	output logic [3:0] CTL_CODE,
	output logic [tw_pkg::BYTE_W-1:0] WORD_ADDR,
	output logic WORD_ADDR_VALID,
	output logic WR_VALID,
	input wire logic WR_READY,
	output logic [tw_pkg::BYTE_W-1:0] WR_DATA,
	input wire logic [tw_pkg::BYTE_W-1:0] RD_DATA,
	output logic RD_TAKE,
	output logic BUSY
);
	import tw_pkg::*;
	typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_MACK, D_WAIT} tw_dev_state_t;
	localparam int WCW = $clog2(WRITE_CYC + 1);
	localparam int HCW = $clog2(HOLD_CYCLES + 1);
	tw_dev_state_t state;
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic [2:0] cs_m, cs_s;
	logic rise, fall, start_c, stop_c, ctl_ok;
	logic [3:0] bit_cnt;
	logic [BYTE_W-1:0] shreg, txreg, push_data;
	logic first, addr_next, is_read, wrote, mack, flush, push_pend;
	logic want_low, drive_low;
	logic [HCW-1:0] hold_cnt;
	logic [WCW-1:0] wr_cnt;
	logic f_in_ready, f_out_valid, discard;
	// ************************************************
	// Pin synchronisers and condition detection
	// ************************************************
	// Two flops per pin; third flop only for edge detection
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
			cs_m <= 3'h0;
			cs_s <= 3'h0;
		end
		else
		begin
			scl_m <= BUS.scl;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= BUS.sda;
			sda_s <= sda_m;
			sda_d <= sda_s;
			cs_m <= CHIP_SEL;
			cs_s <= cs_m;
		end
	end
	// Edges and conditions from synchronised samples
	assign rise = scl_s && !scl_d;
	assign fall = !scl_s && scl_d;
	assign start_c = scl_s && scl_d && sda_d && !sda_s;
	assign stop_c = scl_s && scl_d && !sda_d && sda_s;
	// Control byte match, refused while the write cycle runs
	assign ctl_ok = (shreg[3:1] == cs_s) && !BUSY
		&& ((shreg[7:4] == CODE_ARRAY) || (shreg[7:4] == CODE_PROTECT && !shreg[0]));
	// ************************************************
	// Transfer state machine
	// ************************************************
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state <= D_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			txreg <= 8'h00;
			first <= 1'b0;
			addr_next <= 1'b0;
			is_read <= 1'b0;
			wrote <= 1'b0;
			mack <= 1'b0;
			want_low <= 1'b0;
			flush <= 1'b0;
			push_pend <= 1'b0;
			push_data <= 8'h00;
			CTL_CODE <= 4'h0;
			WORD_ADDR <= 8'h00;
			WORD_ADDR_VALID <= 1'b0;
			RD_TAKE <= 1'b0;
		end
		else
		begin
			flush <= 1'b0;
			WORD_ADDR_VALID <= 1'b0;
			RD_TAKE <= 1'b0;
			if (push_pend && f_in_ready)
				push_pend <= 1'b0;
			if (start_c)
			begin
				// Start, also repeated, restarts framing
				state <= D_RX;
				bit_cnt <= 4'h0;
				first <= 1'b1;
				want_low <= 1'b0;
			end
			else if (stop_c)
			begin
				state <= D_IDLE;
				want_low <= 1'b0;
				wrote <= 1'b0;
			end
			else if (rise)
			begin
				// Bits are taken only on SCL rise
				case (state)
					D_RX:
					begin
						shreg <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end
					D_TX:
						bit_cnt <= bit_cnt + 4'h1;
					D_MACK:
						mack <= !sda_s;
					default:
						mack <= mack;
				endcase
			end
			else if (fall)
			begin
				case (state)
					D_RX:
					begin
						if (bit_cnt == BIT_LAST)
						begin
							first <= 1'b0;
							if (first && !ctl_ok)
								state <= D_WAIT;
							else
							begin
								state <= D_ACK;
								want_low <= 1'b1;
							end
							if (first && ctl_ok)
							begin
								is_read <= shreg[0];
								CTL_CODE <= shreg[7:4];
								addr_next <= !shreg[0];
								flush <= !shreg[0];
							end
							else if (!first && addr_next)
							begin
								addr_next <= 1'b0;
								WORD_ADDR <= shreg;
								WORD_ADDR_VALID <= 1'b1;
							end
							else if (!first)
							begin
								push_pend <= 1'b1;
								push_data <= shreg;
								wrote <= 1'b1;
							end
						end
					end
					D_ACK:
					begin
						bit_cnt <= 4'h0;
						if (is_read)
						begin
							state <= D_TX;
							txreg <= {RD_DATA[6:0], 1'b0};
							want_low <= !RD_DATA[7];
							RD_TAKE <= 1'b1;
						end
						else
						begin
							state <= D_RX;
							want_low <= 1'b0;
						end
					end
					D_TX:
					begin
						if (bit_cnt == BIT_LAST)
						begin
							state <= D_MACK;
							want_low <= 1'b0;
						end
						else
						begin
							want_low <= !txreg[7];
							txreg <= {txreg[6:0], 1'b0};
						end
					end
					D_MACK:
					begin
						bit_cnt <= 4'h0;
						if (mack)
						begin
							state <= D_TX;
							txreg <= {RD_DATA[6:0], 1'b0};
							want_low <= !RD_DATA[7];
							RD_TAKE <= 1'b1;
						end
						else
						begin
							state <= D_WAIT;
							want_low <= 1'b0;
						end
					end
					default:
						want_low <= 1'b0;
				endcase
			end
		end
	end
	// ************************************************
	// Output hold after SCL fall
	// ************************************************
	// New SDA level applied only after the hold count, except the release at Start or Stop
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			hold_cnt <= '0;
			drive_low <= 1'b0;
		end
		else if (start_c || stop_c)
		begin
			hold_cnt <= '0;
			drive_low <= 1'b0;
		end
		else if (fall)
			hold_cnt <= HCW'(HOLD_CYCLES);
		else if (hold_cnt != '0)
		begin
			hold_cnt <= hold_cnt - 1'b1;
			if (hold_cnt == HCW'(1))
				drive_low <= want_low;
		end
	end
	assign BUS.dev_sda_o = 1'b0;
	assign BUS.dev_sda_oe = drive_low;
	// ************************************************
	// Self-timed write cycle
	// ************************************************
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			wr_cnt <= '0;
		else if (stop_c && wrote)
			wr_cnt <= WCW'(WRITE_CYC);
		else if (wr_cnt != '0)
			wr_cnt <= wr_cnt - 1'b1;
	end
	assign BUSY = wr_cnt != '0;
	// ************************************************
	// Page buffer
	// ************************************************
	// When full, the oldest byte is dropped before the new one goes in
	assign discard = push_pend && !f_in_ready;
	assign WR_VALID = f_out_valid && BUSY;
	tw_fifo #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) u_page
	(
		.CLK(CLK),
		.RESETN(RESETN),
		.flush(flush),
		.in_valid(push_pend),
		.in_ready(f_in_ready),
		.in_data(push_data),
		.out_valid(f_out_valid),
		.out_ready(discard || (BUSY && WR_READY)),
		.out_data(WR_DATA)
	);
endmodule
`default_nettype wire

// ---- rtl/tw_host.sv ----
// Master end of the two-wire bus: SCL generation, Start, Stop, byte transfers
`timescale 1ns/1ps
`default_nettype none
module tw_host
#(
	parameter int QTR_CYC = tw_pkg::SCL_QUARTER_CYCLES
)
(
	input wire logic CLK,
	input wire logic RESETN,
	tw_if.host BUS,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire tw_pkg::tw_cmd_t CMD_KIND,
	input wire logic [tw_pkg::BYTE_W-1:0] CMD_DATA,
	input wire logic CMD_ACK,
	output logic RSP_VALID,
	output logic [tw_pkg::BYTE_W-1:0] RSP_DATA,
	output logic RSP_ACK
);
	import tw_pkg::*;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tw_host_state_t;
	localparam int DW = $clog2(QTR_CYC + 1);
	tw_host_state_t state;
	logic [DW-1:0] div;
	logic tick, sda_m, sda_s, scl_out, sda_out, is_read, ack_send;
	logic [1:0] q;
	logic [3:0] bit_cnt;
	logic [BYTE_W-1:0] txreg;
	// ************************************************
	// Quarter-period divider and SDA synchroniser
	// ************************************************
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			div <= '0;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end
		else
		begin
			div <= (div == '0) ? DW'(QTR_CYC - 1) : div - 1'b1;
			sda_m <= BUS.sda;
			sda_s <= sda_m;
		end
	end
	assign tick = div == '0;
	assign CMD_READY = state == H_IDLE;
	// Master owns SCL and drives it always
	assign BUS.host_scl_o = scl_out;
	assign BUS.host_scl_oe = 1'b1;
	assign BUS.host_sda_o = 1'b0;
	assign BUS.host_sda_oe = !sda_out;
	// ************************************************
	// Command sequencer
	// ************************************************
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state <= H_IDLE;
			q <= 2'h0;
			bit_cnt <= 4'h0;
			scl_out <= 1'b1;
			sda_out <= 1'b1;
			is_read <= 1'b0;
			ack_send <= 1'b0;
			txreg <= 8'h00;
			RSP_VALID <= 1'b0;
			RSP_DATA <= 8'h00;
			RSP_ACK <= 1'b0;
		end
		else
		begin
			RSP_VALID <= 1'b0;
			if (state == H_IDLE && CMD_VALID)
			begin
				q <= 2'h0;
				bit_cnt <= 4'h0;
				txreg <= CMD_DATA;
				is_read <= CMD_KIND == TW_CMD_READ;
				ack_send <= CMD_ACK;
				case (CMD_KIND)
					TW_CMD_START: state <= H_START;
					TW_CMD_STOP: state <= H_STOP;
					default: state <= H_BIT;
				endcase
			end
			else if (tick && state != H_IDLE)
			begin
				q <= q + 2'h1;
				case (state)
					H_START:
					begin
						// SDA falls while SCL is high
						case (q)
							2'h0: sda_out <= 1'b1;
							2'h1: scl_out <= 1'b1;
							2'h2: sda_out <= 1'b0;
							default:
							begin
								scl_out <= 1'b0;
								state <= H_IDLE;
							end
						endcase
					end
					H_STOP:
					begin
						// SDA rises while SCL is high, bus left idle
						case (q)
							2'h0: sda_out <= 1'b0;
							2'h1: scl_out <= 1'b1;
							2'h2: sda_out <= 1'b1;
							default: state <= H_IDLE;
						endcase
					end
					default:
					begin
						case (q)
							2'h0:
							begin
								// Data changes only while SCL is low
								if (bit_cnt != BIT_LAST)
									sda_out <= is_read || txreg[7];
								else
									sda_out <= !(is_read && ack_send);
							end
							2'h1: scl_out <= 1'b1;
							2'h2:
							begin
								if (bit_cnt != BIT_LAST)
									RSP_DATA <= {RSP_DATA[6:0], sda_s};
								else
									RSP_ACK <= !sda_s;
							end
							default:
							begin
								scl_out <= 1'b0;
								txreg <= {txreg[6:0], 1'b0};
								bit_cnt <= bit_cnt + 4'h1;
								if (bit_cnt == BIT_LAST)
								begin
									state <= H_IDLE;
									RSP_VALID <= 1'b1;
								end
							end
						endcase
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/tw_properties.sv ----
// Concurrent checks on the two-wire bus between the slave end and the master end
`timescale 1ns/1ps
`default_nettype none
module tw_properties
import tw_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe
);
	logic scl_d, sda_d, first, quiet, start, stop;
	logic [3:0] bitn;
	logic [7:0] fcnt;
	// ****************************************
	// Helper logic
	// ****************************************
	assign start = scl && scl_d && sda_d && !sda;
	assign stop = scl && scl_d && !sda_d && sda;
	// Previous line levels for edge finding
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			{scl_d, sda_d} <= 2'h3;
		else
			{scl_d, sda_d} <= {scl, sda};
	end
	// Pulse number within the current byte
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			bitn <= 4'h0;
		else if (start)
			bitn <= 4'h0;
		else if (scl && !scl_d)
			bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
	end
	// High while the first byte after a Start is on the bus
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			first <= 1'b0;
		else if (start)
			first <= 1'b1;
		else if (scl && !scl_d && bitn == 4'h9)
			first <= 1'b0;
	end
	// Set by an unanswered ninth pulse, cleared by a condition
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			quiet <= 1'b0;
		else if (start || stop)
			quiet <= 1'b0;
		else if (scl && !scl_d && bitn == 4'h8 && sda)
			quiet <= 1'b1;
	end
	// Cycles since the last SCL fall, saturating
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			fcnt <= 8'hFF;
		else if (!scl && scl_d)
			fcnt <= 8'h01;
		else if (fcnt != 8'hFF)
			fcnt <= fcnt + 8'h01;
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	chk_idle_at_reset: assert property ($rose(RESETN) |-> scl && sda)
		else $error("bus not idle after reset");
	chk_stop_to_idle: assert property (stop |-> (scl && sda && !dev_sda_oe) [*8])
		else $error("bus not idle after stop");
	chk_drive_on_low: assert property ($rose(dev_sda_oe) |-> !scl && !scl_d)
		else $error("slave pulled data while clock high");
	chk_ack_through_high: assert property (scl && dev_sda_oe |=> dev_sda_oe || !scl)
		else $error("slave released data during clock high");
	chk_hold_after_fall: assert property (!scl && $changed(dev_sda_oe) |-> fcnt >= HOLD_CYCLES)
		else $error("slave data changed too soon after clock fall");
	chk_ctl_byte_quiet: assert property (first && scl && scl_d && bitn <= 4'h8 |-> !dev_sda_oe)
		else $error("slave drove during control byte");
	chk_nack_release: assert property (quiet |-> !dev_sda_oe)
		else $error("slave drove after unanswered ninth pulse");
	chk_clock_high_len: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high pulse too short");
endmodule
`default_nettype wire

// ---- dv/two_wire_slave_bus_frontend_test.sv ----
// Bench joining the master end and the slave end across one two-wire bus
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_bus_frontend_test;
	import tw_pkg::*;
	localparam int QTR = 70;
	localparam int WRC = 4000;
	logic CLK, RESETN, cmd_valid, cmd_ready, cmd_ack, rsp_valid, rsp_ack;
	logic wr_valid, wr_ready, rd_take, busy, word_addr_valid;
	logic [7:0] addr_pulses;
	int busy_cycles;
	logic [2:0] chip_sel;
	logic [3:0] ctl_code;
	logic [7:0] cmd_data, rsp_data, word_addr, wr_data, rd_data, got_ack, got_data;
	logic [7:0] drained[$];
	tw_cmd_t cmd_kind;
	int errors, tests_run;
	tw_if tw_bus();
	tw_dev #(.WRITE_CYC(WRC), .DEPTH(PAGE_BYTES)) tw_dev_inst (.CLK(CLK), .RESETN(RESETN),
		.BUS(tw_bus.dev), .CHIP_SEL(chip_sel), .CTL_CODE(ctl_code), .WORD_ADDR(word_addr),
		.WORD_ADDR_VALID(word_addr_valid), .WR_VALID(wr_valid), .WR_READY(wr_ready),
		.WR_DATA(wr_data),
		.RD_DATA(rd_data), .RD_TAKE(rd_take), .BUSY(busy));
	tw_host #(.QTR_CYC(QTR)) tw_host_inst (.CLK(CLK), .RESETN(RESETN), .BUS(tw_bus.host),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_KIND(cmd_kind),
		.CMD_DATA(cmd_data), .CMD_ACK(cmd_ack), .RSP_VALID(rsp_valid),
		.RSP_DATA(rsp_data), .RSP_ACK(rsp_ack));
	tw_properties tw_properties_inst (.CLK(CLK), .RESETN(RESETN), .scl(tw_bus.scl),
		.sda(tw_bus.sda), .dev_sda_oe(tw_bus.dev_sda_oe));
	// ****************************************
	// Clock, user-side partners and watchdog
	// ****************************************
	initial
	begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	// Drain side stalls every other cycle; read data steps per byte taken
	// Address pulses and write-cycle length are counted for later checks
	always @(posedge CLK)
	begin
		wr_ready <= !wr_ready;
		if (word_addr_valid === 1'b1)
			addr_pulses <= addr_pulses + 8'h01;
		if (busy === 1'b1)
			busy_cycles <= busy_cycles + 1;
		if (wr_valid === 1'b1 && wr_ready === 1'b1)
			drained.push_back(wr_data);
		if (rd_take === 1'b1)
			rd_data <= rd_data + 8'h11;
	end
	// Cuts a hung run short
	initial
	begin
		repeat (95000) @(posedge CLK);
		errors++;
		finish_test();
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One master command, held until taken; byte commands wait for the answer
	task automatic cmd(input tw_cmd_t k, input logic [7:0] d, input logic a);
		int n;
		n = 0;
		@(posedge CLK);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_data <= d;
		cmd_ack <= a;
		@(posedge CLK);
		while (cmd_ready !== 1'b1 && n < 5000)
		begin
			@(posedge CLK);
			n++;
		end
		cmd_valid <= 1'b0;
		if (k == TW_CMD_WRITE || k == TW_CMD_READ)
		begin
			@(posedge CLK);
			while (rsp_valid !== 1'b1 && n < 5000)
			begin
				@(posedge CLK);
				n++;
			end
			got_ack = {7'h0, rsp_ack};
			got_data = rsp_data;
		end
		chk("cmd_done", {7'h0, n < 5000}, 8'h01);
	endtask
	task automatic test_page_write();
		int n;
		n = 0;
		cmd(TW_CMD_START, 8'h00, 1'b0);
		cmd(TW_CMD_WRITE, {CODE_ARRAY, 3'h5, 1'b0}, 1'b0);
		chk("ctl_ack", got_ack, 8'h01);
		cmd(TW_CMD_WRITE, 8'h40, 1'b0);
		chk("addr_ack", got_ack, 8'h01);
		chk("word_addr", word_addr, 8'h40);
		chk("addr_pulse", addr_pulses, 8'h01);
		chk("ctl_code", {4'h0, ctl_code}, {4'h0, CODE_ARRAY});
		for (int i = 0; i < 17; i++)
		begin
			cmd(TW_CMD_WRITE, 8'h10 + i[7:0], 1'b0);
			chk("data_ack", got_ack, 8'h01);
		end
		cmd(TW_CMD_STOP, 8'h00, 1'b0);
		// Poll while the self-timed write runs
		cmd(TW_CMD_START, 8'h00, 1'b0);
		cmd(TW_CMD_WRITE, {CODE_ARRAY, 3'h5, 1'b0}, 1'b0);
		chk("busy_nack", got_ack, 8'h00);
		chk("busy", {7'h0, busy}, 8'h01);
		cmd(TW_CMD_STOP, 8'h00, 1'b0);
		while (busy === 1'b1 && n < WRC)
		begin
			@(posedge CLK);
			n++;
		end
		chk("busy_end", {7'h0, busy}, 8'h00);
		chk("busy_len", {7'h0, busy_cycles == WRC}, 8'h01);
		chk("drained", 8'(drained.size()), 8'h10);
		for (int i = 0; i < 16; i++)
			chk("page_byte", drained[i], 8'h11 + i[7:0]);
		cmd(TW_CMD_START, 8'h00, 1'b0);
		cmd(TW_CMD_WRITE, {CODE_ARRAY, 3'h5, 1'b0}, 1'b0);
		chk("idle_ack", got_ack, 8'h01);
		cmd(TW_CMD_STOP, 8'h00, 1'b0);
		$display("test page_write done");
	endtask
	// Wrong chip select, protect code with read, protect code with write
	task automatic test_refusals();
		logic [7:0] ctl[3] = '{8'hA4, 8'h6B, 8'h6A};
		logic [7:0] exp[3] = '{8'h00, 8'h00, 8'h01};
		for (int i = 0; i < 3; i++)
		begin
			cmd(TW_CMD_START, 8'h00, 1'b0);
			cmd(TW_CMD_WRITE, ctl[i], 1'b0);
			chk("ctl_refuse", got_ack, exp[i]);
			cmd(TW_CMD_STOP, 8'h00, 1'b0);
		end
		chk("ctl_code", {4'h0, ctl_code}, {4'h0, CODE_PROTECT});
		$display("test refusals done");
	endtask
	// Two bytes read, the last one left unanswered by the master
	task automatic test_read();
		cmd(TW_CMD_START, 8'h00, 1'b0);
		cmd(TW_CMD_WRITE, {CODE_ARRAY, 3'h5, 1'b1}, 1'b0);
		chk("rd_ctl_ack", got_ack, 8'h01);
		cmd(TW_CMD_READ, 8'h00, 1'b1);
		chk("rd_byte", got_data, 8'h3C);
		cmd(TW_CMD_READ, 8'h00, 1'b0);
		chk("rd_last", got_data, 8'h4D);
		repeat (2 * QTR) @(posedge CLK);
		chk("sda_free", {7'h0, tw_bus.dev_sda_oe}, 8'h00);
		cmd(TW_CMD_STOP, 8'h00, 1'b0);
		$display("test read done");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		errors = 0;
		tests_run = 0;
		RESETN = 1'b0;
		cmd_valid = 1'b0;
		cmd_kind = TW_CMD_START;
		cmd_data = 8'h00;
		cmd_ack = 1'b0;
		chip_sel = 3'h5;
		wr_ready = 1'b0;
		rd_data = 8'h3C;
		addr_pulses = 8'h00;
		busy_cycles = 0;
		repeat (6) @(posedge CLK);
		RESETN <= 1'b1;
		repeat (4) @(posedge CLK);
		test_page_write();
		test_refusals();
		test_read();
		finish_test();
	end
endmodule
`default_nettype wire
